// >>> verilog/clcf_closed_loop_cfg.sv
/*
 * Register bank for the lower closed-loop settings: deceleration rate,
 * switching frequency, modulation style and three enables, plus decoded
 * control outputs for the motor-control logic.
 * Assumes a single-cycle strobe master on one synchronous clock domain.
 */
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "clcf_consts.svh"

module clcf_closed_loop_cfg
    import clcf_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [`CLCF_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic [31:0] cfg_word_out,
    output clcf_fields_t fields_out,
    output clcf_ctrl_t ctrl_out
);

    logic [31:0] cl1_reg;
    logic [31:0] cl1_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    clcf_ctrl_t ctrl_reg;
    clcf_ctrl_t ctrl_next;
    clcf_fields_t fields;
    logic [31:0] rate_x2;
    logic [15:0] freq_khz;
    logic freq_valid;
    logic use_own_decel;

    // Upper bits of the word belong to other logic and bit 0 is unused,
    // so those bits store nothing here and read as zero.
    always_comb begin
        cl1_next = cl1_reg;
        if (wr_in && (addr_in == `CLCF_OFS_CL1)) begin
            cl1_next = wdata_in & `CLCF_WRITE_MASK;
        end
    end

    always_comb begin
        fields.decel_rate_code = cl1_reg[`CLCF_DEC_MSB:`CLCF_DEC_LSB];
        fields.decel_source_select = cl1_reg[`CLCF_DECSRC_BIT];
        fields.switching_freq_code = cl1_reg[`CLCF_FREQ_MSB:`CLCF_FREQ_LSB];
        fields.surge_protect_enable = cl1_reg[`CLCF_SURGE_BIT];
        fields.deadtime_comp_enable = cl1_reg[`CLCF_DTC_BIT];
        fields.velocity_loop_off = cl1_reg[`CLCF_VLOOP_BIT];
    end

    clcf_rate_lut u_rate (
        .code_in(fields.decel_rate_code),
        .rate_x2_out(rate_x2)
    );

    clcf_freq_map u_freq (
        .code_in(fields.switching_freq_code),
        .khz_out(freq_khz),
        .valid_out(freq_valid)
    );

    always_comb begin
        use_own_decel = !fields.surge_protect_enable && !fields.decel_source_select;
        ctrl_next.decel_from_own_field = use_own_decel;
        // When the field is ignored the limit reads as zero; the consumer
        // takes its rate from the acceleration field or the surge logic.
        ctrl_next.decel_limit_x2 = use_own_decel ? rate_x2 : 32'h0000_0000;
        ctrl_next.pwm_freq_khz = freq_khz;
        ctrl_next.pwm_freq_valid = freq_valid;
        ctrl_next.modulation = cl1_reg[`CLCF_MODE_BIT] ? CLCF_MOD_DISC : CLCF_MOD_CONT;
    end

    always_comb begin
        case (addr_in)
            `CLCF_OFS_CL1: rdata_next = cl1_reg;
            `CLCF_OFS_STATUS: rdata_next = {15'h0000, ctrl_reg.pwm_freq_khz[14:0],
                                           ctrl_reg.pwm_freq_valid,
                                           ctrl_reg.decel_from_own_field};
            default: rdata_next = 32'h0000_0000;
        endcase
        if (!rd_in) begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cl1_reg <= `CLCF_RESET_CL1;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= '{decel_from_own_field: 1'b1, decel_limit_x2: 32'h0000_0001,
                          pwm_freq_khz: `CLCF_FREQ_BASE_KHZ, pwm_freq_valid: 1'b1,
                          modulation: CLCF_MOD_CONT};
        end else begin
            cl1_reg <= cl1_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
        end
    end

    assign rdata_out = rdata_reg;
    assign cfg_word_out = cl1_reg;
    assign fields_out = fields;
    assign ctrl_out = ctrl_reg;

endmodule : clcf_closed_loop_cfg
`default_nettype wire

// >>> verilog/clcf_consts.svh
/*
 * Offsets, field positions, reset values and lookup figures for the
 * closed-loop settings word. Assumes inclusion by bare name.
 */
`ifndef CLCF_CONSTS_SVH
`define CLCF_CONSTS_SVH

`define CLCF_ADDR_W 8
`define CLCF_OFS_CL1 8'h38
`define CLCF_OFS_STATUS 8'h3C
`define CLCF_RESET_CL1 32'h0000_0000
`define CLCF_WRITE_MASK 32'h0000_7FFE

`define CLCF_DEC_MSB 12
`define CLCF_DEC_LSB 8
`define CLCF_DECSRC_BIT 13
`define CLCF_ACC_MSB 18
`define CLCF_ACC_LSB 14
`define CLCF_FREQ_MSB 7
`define CLCF_FREQ_LSB 4
`define CLCF_MODE_BIT 14
`define CLCF_SURGE_BIT 3
`define CLCF_DTC_BIT 2
`define CLCF_VLOOP_BIT 1

`define CLCF_FREQ_MAX_CODE 4'hD
`define CLCF_FREQ_BASE_KHZ 16'h000A
`define CLCF_FREQ_STEP_KHZ 16'h0005
`define CLCF_RATE_NOLIMIT_CODE 5'h1F
`define CLCF_RATE_NOLIMIT 32'hFFFF_FFFF

`endif

// >>> verilog/clcf_pkg.sv
/*
 * Types shared by the closed-loop configuration block.
 * Assumes the constants header is on the include path.
 */
`include "clcf_consts.svh"

package clcf_pkg;

    typedef enum logic [1:0] {
        CLCF_MOD_CONT = 2'b01,
        CLCF_MOD_DISC = 2'b10
    } clcf_mod_t;

    typedef struct packed {
        logic [4:0] decel_rate_code;
        logic decel_source_select;
        logic [3:0] switching_freq_code;
        logic surge_protect_enable;
        logic deadtime_comp_enable;
        logic velocity_loop_off;
    } clcf_fields_t;

    typedef struct packed {
        logic decel_from_own_field;
        logic [31:0] decel_limit_x2;
        logic [15:0] pwm_freq_khz;
        logic pwm_freq_valid;
        clcf_mod_t modulation;
    } clcf_ctrl_t;

endpackage : clcf_pkg

// >>> verilog/clcf_rate_lut.sv
/*
 * Maps the five-bit deceleration code onto a rate in half hertz per second.
 * Purely combinational; assumes nothing of its surroundings.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clcf_consts.svh"

module clcf_rate_lut
    import clcf_pkg::*;
(
    input wire logic [4:0] code_in,
    output logic [31:0] rate_x2_out
);

    // Rates are doubled so the 0.5 Hz/s entry stays an integer.
    always_comb begin
        case (code_in)
            5'h00: rate_x2_out = 32'h0000_0001;
            5'h01: rate_x2_out = 32'h0000_0002;
            5'h02: rate_x2_out = 32'h0000_0005;
            5'h03: rate_x2_out = 32'h0000_000A;
            5'h04: rate_x2_out = 32'h0000_000F;
            5'h05: rate_x2_out = 32'h0000_0014;
            5'h06: rate_x2_out = 32'h0000_0028;
            5'h07: rate_x2_out = 32'h0000_0050;
            5'h08: rate_x2_out = 32'h0000_0078;
            5'h09: rate_x2_out = 32'h0000_00A0;
            5'h0A: rate_x2_out = 32'h0000_00C8;
            5'h0B: rate_x2_out = 32'h0000_0190;
            5'h0C: rate_x2_out = 32'h0000_0258;
            5'h0D: rate_x2_out = 32'h0000_0320;
            5'h0E: rate_x2_out = 32'h0000_03E8;
            5'h0F: rate_x2_out = 32'h0000_04B0;
            5'h10: rate_x2_out = 32'h0000_0578;
            5'h11: rate_x2_out = 32'h0000_0640;
            5'h12: rate_x2_out = 32'h0000_0708;
            5'h13: rate_x2_out = 32'h0000_07D0;
            5'h14: rate_x2_out = 32'h0000_0FA0;
            5'h15: rate_x2_out = 32'h0000_1F40;
            5'h16: rate_x2_out = 32'h0000_2EE0;
            5'h17: rate_x2_out = 32'h0000_3E80;
            5'h18: rate_x2_out = 32'h0000_4E20;
            5'h19: rate_x2_out = 32'h0000_9C40;
            5'h1A: rate_x2_out = 32'h0000_EA60;
            5'h1B: rate_x2_out = 32'h0001_3880;
            5'h1C: rate_x2_out = 32'h0001_86A0;
            5'h1D: rate_x2_out = 32'h0001_D4C0;
            5'h1E: rate_x2_out = 32'h0002_22E0;
            default: rate_x2_out = `CLCF_RATE_NOLIMIT;
        endcase
    end

endmodule : clcf_rate_lut
`default_nettype wire

// >>> verilog/clcf_freq_map.sv
/*
 * Turns the switching frequency code into kilohertz and a validity flag.
 * Purely combinational; assumes nothing of its surroundings.
 */
`timescale 1ns/1ps
`default_nettype none
`include "clcf_consts.svh"

module clcf_freq_map
    import clcf_pkg::*;
(
    input wire logic [3:0] code_in,
    output logic [15:0] khz_out,
    output logic valid_out
);

    always_comb begin
        valid_out = (code_in <= `CLCF_FREQ_MAX_CODE);
        // Invalid codes report zero so downstream logic cannot run off-table.
        if (valid_out) begin
            khz_out = 16'(`CLCF_FREQ_BASE_KHZ + `CLCF_FREQ_STEP_KHZ * {12'h000, code_in});
        end else begin
            khz_out = 16'h0000;
        end
    end

endmodule : clcf_freq_map
`default_nettype wire

// >>> testbench/clcf_cfg_chk.sv
/* Assertions on the ports of the closed-loop settings bank.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "clcf_consts.svh"
module clcf_cfg_chk
    import clcf_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic [`CLCF_ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [31:0] cfg_word_out,
    input wire clcf_ctrl_t ctrl_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic own;
    logic [3:0] fc;
    assign own = !cfg_word_out[3] && !cfg_word_out[13];
    assign fc = cfg_word_out[7:4];
    sequence s_wr; wr_in && addr_in == `CLCF_OFS_CL1; endsequence
    sequence s_rd; rd_in && addr_in == `CLCF_OFS_CL1; endsequence
    property p_wr; s_wr |=> cfg_word_out == $past(wdata_in & `CLCF_WRITE_MASK); endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_rd; s_rd |=> rdata_out == $past(cfg_word_out); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_rsv; cfg_word_out[31:15] == 17'h0 && !cfg_word_out[0]; endproperty
    a_rsv: assert property (p_rsv) else $error("dropped bits stored");
    property p_own; 1'b1 |=> ctrl_out.decel_from_own_field == $past(own); endproperty
    a_own: assert property (p_own) else $error("field use wrong");
    property p_ign; !own |=> ctrl_out.decel_limit_x2 == 32'h0; endproperty
    a_ign: assert property (p_ign) else $error("ignored field applied");
    property p_nolim; own && cfg_word_out[12:8] == 5'h1F |=> &ctrl_out.decel_limit_x2; endproperty
    a_nolim: assert property (p_nolim) else $error("no limit code wrong");
    property p_freq;
        fc <= 4'hD |=> ctrl_out.pwm_freq_valid && ctrl_out.pwm_freq_khz == 16'h000A + 16'h0005 * $past(fc);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency wrong");
    property p_inv; fc > 4'hD |=> !ctrl_out.pwm_freq_valid; endproperty
    a_inv: assert property (p_inv) else $error("invalid code accepted");
    property p_mod;
        1'b1 |=> ctrl_out.modulation == ($past(cfg_word_out[14]) ? CLCF_MOD_DISC : CLCF_MOD_CONT);
    endproperty
    a_mod: assert property (p_mod) else $error("modulation wrong");
endmodule : clcf_cfg_chk
bind clcf_closed_loop_cfg clcf_cfg_chk chk_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cfg_word_out(cfg_word_out), .ctrl_out(ctrl_out));
`default_nettype wire

// >>> testbench/closed_loop_config_fields_test.sv
/* Self-checking bench for the closed-loop settings bank.
   Assumes the package and constants header are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "clcf_consts.svh"
module closed_loop_config_fields_test
    import clcf_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [31:0] cfg_word_out;
    clcf_fields_t fields_out;
    clcf_ctrl_t ctrl_out;
    int failures = 0;
    int checks = 0;
    logic [4:0] dc [5] = '{5'h00, 5'h01, 5'h02, 5'h1E, 5'h1F};
    logic [31:0] dl [5] = '{32'h1, 32'h2, 32'h5, 32'h0002_22E0, 32'hFFFF_FFFF};
    always #20 core_clk_in = ~core_clk_in;
    clcf_closed_loop_cfg dut_u (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .cfg_word_out(cfg_word_out), .fields_out(fields_out), .ctrl_out(ctrl_out));
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Returns once the decoded controls of the written word have landed.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(64'(rdata_out), 64'(exp));
    endtask : rd
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    initial begin
        #100000;
        failures++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk(64'(ctrl_out), 64'({1'b1, 32'h1, 16'h000A, 1'b1, CLCF_MOD_CONT}));
        rd(8'h38, 32'h0);
        $display("test reset done");
        wr(8'h38, 32'hFFFF_FFFF);
        rd(8'h38, 32'h0000_7FFE);
        chk(64'(fields_out), 64'h1FFF);
        chk(64'(ctrl_out), 64'({1'b0, 32'h0, 16'h0, 1'b0, CLCF_MOD_DISC}));
        wr(8'h3C, 32'h0);
        rd(8'h38, 32'h0000_7FFE);
        rd(8'h40, 32'h0);
        $display("test access done");
        for (int i = 0; i < 5; i++) begin
            wr(8'h38, {19'h0, dc[i], 8'h00});
            chk(64'(ctrl_out.decel_limit_x2), 64'(dl[i]));
            wr(8'h38, {18'h0, ~i[0], dc[i], 8'h00} | {28'h0, i[0], 3'h0});
            chk(64'({ctrl_out.decel_from_own_field, ctrl_out.decel_limit_x2}), 64'h0);
        end
        $display("test decel done");
        // A reset in mid-run must clear every stored field and return the decoded controls to their reset values.
        @(posedge core_clk_in);
        nrst_in <= 1'b0;
        @(posedge core_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk(64'(cfg_word_out), 64'h0);
        chk(64'(ctrl_out), 64'({1'b1, 32'h1, 16'h000A, 1'b1, CLCF_MOD_CONT}));
        rd(8'h38, 32'h0);
        $display("test reset again done");
        for (int f = 0; f < 16; f++) begin
            wr(8'h38, {17'h0, f[0], 6'h00, f[3:0], 4'h0});
            chk(64'({ctrl_out.pwm_freq_khz, ctrl_out.pwm_freq_valid}),
                (f <= 13) ? 64'({16'(10 + 5 * f), 1'b1}) : 64'h0);
            chk(64'(ctrl_out.modulation), f[0] ? 64'(CLCF_MOD_DISC) : 64'(CLCF_MOD_CONT));
            rd(8'h3C, {15'h0, ((f <= 13) ? 15'(10 + 5 * f) : 15'h0), 1'(f <= 13), 1'b1});
        end
        $display("test pwm done");
        close_out();
    end
endmodule : closed_loop_config_fields_test
`default_nettype wire
